// [sim/udes_host_model.sv]
// udes_host_model.sv: bus host model driving the D+ and D- pins of the device.
// assumes: the bench changes the mode just after a rising edge of i_clk.
`timescale 1ns/1ns
module udes_host_model (
    input  wire logic       i_clk,  // core clock
    input  wire logic [1:0] i_mode, // 0 traffic, 1 idle, 2 resume
    output logic            o_dp,   // D+ pin
    output logic            o_dm    // D- pin
);
    logic tgl_r;

    initial tgl_r = 1'b0;

    always @(posedge i_clk) begin
        tgl_r <= ~tgl_r;
    end

    // ----------------------------------------------------------------------
    // line states: idle is J, resume is K, traffic alternates every cycle
    // ----------------------------------------------------------------------
    always_comb begin
        o_dp = (i_mode == 2'h1) ? 1'b1 : ((i_mode == 2'h2) ? 1'b0 : tgl_r);
        o_dm = ~o_dp;
    end
endmodule

// [sim/udes_top_tb_top.sv]
// udes_top_tb_top.sv: self-checking bench of the event and status registers.
// assumes: the host model drives the pins; the suspend count is shortened to 16.
`timescale 1ns/1ns
module udes_top_tb_top;
    logic        clk, rst_n, wr, rd, dp, dm, crc, awake, ready;
    logic        bus_ev, xfer_ev, susp, irq;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, m;
    logic [8:0]  dci, dco, vi, vo;
    logic [7:1]  aki, ako, vai, vao;
    logic [7:0]  hin, hout;
    logic [6:0]  baddr;
    logic [1:0]  hmode;
    int          bad_count, checks_done, n, w;

    udes_top #(.P_SUSP_IDLE_CYC(20'h10)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_dp(dp), .i_dm(dm), .i_iso_crc_err(crc), .i_mac_awake(awake),
        .i_dev_ready(ready), .i_dma_cap_in(dci), .i_dma_cap_out(dco),
        .i_ack_in(aki), .i_ack_out(ako), .i_in_halted(hin), .i_out_halted(hout),
        .i_bus_addr(baddr), .o_bus_event(bus_ev), .o_ep_xfer_event(xfer_ev),
        .o_suspended(susp), .o_irq(irq));
    udes_host_model i_host (.i_clk(clk), .i_mode(hmode), .o_dp(dp), .o_dm(dm));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] ep_word(input logic [8:0] i, input logic [8:0] o);
        return {7'h0, o, 7'h0, i};
    endfunction

    task results;
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask

    task pulse(input logic c, input logic [8:0] di, input logic [8:0] dout,
               input logic [7:1] ai, input logic [7:1] ao);
        @(posedge clk);
        crc <= c;
        dci <= di;
        dco <= dout;
        aki <= ai;
        ako <= ao;
        #1;
        chk("xfer_event", {31'h0, |{ai, ao}}, {31'h0, xfer_ev});
        chk("bus_event", {31'h0, c}, {31'h0, bus_ev});
        @(posedge clk);
        {crc, dci, dco, aki, ako} <= '0;
    endtask

    task wait_susp(input logic lvl);
        w = 0;
        while (susp !== lvl && w < 40) begin
            @(posedge clk);
            #1;
            w++;
        end
        if (w >= 40) begin
            bad_count++;
            results();
        end
    endtask

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        {rst_n, wr, rd, crc, awake, ready, dci, dco, aki, ako} = '0;
        {addr, wdata, hin, hout, baddr, hmode} = '0;
        bad_count = 0;
        checks_done = 0;
        void'($urandom(37504));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(12'h400, 32'h0, "cause_reset");
        rd_chk(12'h468, 32'h0, "dma_reset");
        rd_chk(12'h46C, 32'h0, "ack_reset");
        pulse(1'b1, 9'h0, 9'h0, 7'h0, 7'h0);
        awake <= 1'b1;
        ready <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(12'h400, 32'h19, "cause_set");
        wr_reg(12'h400, 32'h11);
        rd_chk(12'h400, 32'h08, "cause_w1c");
        wr_reg(12'h400, 32'h08);
        rd_chk(12'h400, 32'h0, "cause_w1c");
        for (n = 0; n < 6; n++) begin
            vi = (n == 0) ? 9'h1FF : 9'($urandom);
            vo = (n == 0) ? 9'h1FF : 9'($urandom);
            vai = (n == 0) ? 7'h7F : 7'($urandom);
            vao = (n == 0) ? 7'h7F : 7'($urandom);
            m = $urandom;
            pulse(1'b0, vi, vo, vai, vao);
            rd_chk(12'h468, ep_word(vi, vo), "dma_cap");
            rd_chk(12'h46C, ep_word({1'b0, vai, 1'b0}, {1'b0, vao, 1'b0}), "ack");
            wr_reg(12'h468, m);
            rd_chk(12'h468, ep_word(vi, vo) & ~m, "dma_w1c");
            wr_reg(12'h468, 32'hFFFFFFFF);
            wr_reg(12'h46C, 32'hFFFFFFFF);
            rd_chk(12'h46C, 32'h0, "ack_w1c");
        end
        hin <= 8'($urandom);
        hout <= 8'($urandom);
        baddr <= 7'($urandom);
        @(posedge clk);
        for (n = 0; n < 8; n++) begin
            rd_chk(12'h420 + 12'(4 * n), {31'h0, hin[n]}, "in_halted");
            rd_chk(12'h444 + 12'(4 * n), {31'h0, hout[n]}, "out_halted");
        end
        wr_reg(12'h470, {25'h0, ~baddr});
        rd_chk(12'h470, {25'h0, baddr}, "bus_addr");
        rd_chk(12'h47C, 32'h0, "unmapped");
        hmode <= 2'h1;
        wait_susp(1'b1);
        chk("susp_time", 32'h1, {31'h0, (w >= 16 && w <= 22)});
        rd_chk(12'h400, 32'h02, "cause_suspend");
        hmode <= 2'h2;
        wait_susp(1'b0);
        rd_chk(12'h400, 32'h06, "cause_resume");
        hmode <= 2'h0;
        wr_reg(12'h400, 32'h1F);
        rd_chk(12'h400, 32'h0, "cause_clear");
        wr_reg(12'h504, 32'h7);
        rd_chk(12'h500, 32'h0, "irq_status");
        wr_reg(12'h508, 32'h2);
        rd_chk(12'h508, 32'h2, "irq_enable");
        pulse(1'b0, 9'h0, 9'h0, 7'h01, 7'h0);
        rd_chk(12'h500, 32'h2, "irq_status");
        chk("irq_on", 32'h1, {31'h0, irq});
        wr_reg(12'h508, 32'h0);
        #1;
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr_reg(12'h508, 32'h2);
        #1;
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        wr_reg(12'h504, 32'h2);
        #1;
        chk("irq_cleared", 32'h0, {31'h0, irq});
        rd_chk(12'h504, 32'h0, "irq_clear_read");
        results();
    end
endmodule

// [verilog/udes_defines.svh]
// udes_defines.svh: offsets, field positions, reset values and timing counts
// of the device event and status register group.
// assumes: included by bare name from the design modules.
`ifndef UDES_DEFINES_SVH
`define UDES_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define UDES_OFS_EVT_CAUSE    12'h400
`define UDES_OFS_IN_HALT      12'h420
`define UDES_OFS_OUT_HALT     12'h444
`define UDES_OFS_EP_STRIDE    12'h004
`define UDES_OFS_DMA_CAP      12'h468
`define UDES_OFS_ACK_XFER     12'h46C
`define UDES_OFS_BUS_ADDR     12'h470
`define UDES_OFS_IRQ_STATUS   12'h500
`define UDES_OFS_IRQ_CLEAR    12'h504
`define UDES_OFS_IRQ_ENABLE   12'h508

// ----------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------
`define UDES_EVT_ISO_CRC      0
`define UDES_EVT_SUSPEND      1
`define UDES_EVT_RESUME       2
`define UDES_EVT_WAKEUP       3
`define UDES_EVT_READY        4
`define UDES_EVT_MASK         32'h0000001F
`define UDES_DMA_MASK         32'h01FF01FF
`define UDES_ACK_MASK         32'h00FE00FE
`define UDES_HALT_EP_COUNT    8
`define UDES_IRQ_BUS_EVENT    0
`define UDES_IRQ_EP_XFER      1
`define UDES_IRQ_DMA_CAP      2
`define UDES_IRQ_WIDTH        3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UDES_RST_FLAGS        32'h00000000
`define UDES_RST_IRQ          3'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define UDES_CLK_PERIOD_NS    4
`define UDES_SUSP_IDLE_NS     3000000
`define UDES_SUSP_IDLE_CYC    (`UDES_SUSP_IDLE_NS / `UDES_CLK_PERIOD_NS)
`define UDES_LINE_J           2'h2

`endif

// [verilog/udes_flags.sv]
// udes_flags.sv: bank of sticky write-one-to-clear flags.
// assumes: set and clear come from logic on i_clk; set wins over clear.
`timescale 1ns/1ns
`include "udes_defines.svh"
module udes_flags (
    input  wire logic        i_clk,    // core clock
    input  wire logic        i_rst_n,  // sync reset, active low
    input  wire logic [31:0] i_mask,   // implemented bits
    input  wire logic [31:0] i_set,    // set pulses
    input  wire logic [31:0] i_clr,    // write-one-to-clear bits
    output logic      [31:0] o_flags   // flag state
);
    udes_pkg::udes_flag_state_t st_r;
    udes_pkg::udes_flag_state_t st_nxt;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.flags_r = ((st_r.flags_r & ~i_clr) | i_set) & i_mask;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r.flags_r <= `UDES_RST_FLAGS;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_flags = st_r.flags_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_set_wins_clr: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_set[0] && i_mask[0]) |=> o_flags[0])
        else $error("flag set lost against clear");
    a_clr_drops_bit: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_clr[0] && !i_set[0]) |=> !o_flags[0])
        else $error("flag not cleared by write one");
endmodule

// [verilog/udes_irq.sv]
// udes_irq.sv: sticky interrupt status, write-only clear, enable, level output.
// assumes: events are one-cycle pulses on i_clk.
`timescale 1ns/1ns
`include "udes_defines.svh"
module udes_irq (
    input  wire logic       i_clk,     // core clock
    input  wire logic       i_rst_n,   // sync reset, active low
    input  wire logic [2:0] i_event,   // event pulses
    input  wire logic [2:0] i_clr,     // clear bits, one-cycle
    input  wire logic       i_en_we,   // enable register write
    input  wire logic [2:0] i_en_data, // enable write data
    output logic      [2:0] o_status,  // sticky status
    output logic      [2:0] o_enable,  // enable register
    output logic            o_irq      // level interrupt
);
    udes_pkg::udes_irq_state_t st_r;
    udes_pkg::udes_irq_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.status_r = (st_r.status_r & ~i_clr) | i_event;
        if (i_en_we) begin
            st_nxt.enable_r = i_en_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r.status_r <= `UDES_RST_IRQ;
            st_r.enable_r <= `UDES_RST_IRQ;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_status = st_r.status_r;
    assign o_enable = st_r.enable_r;
    assign o_irq    = |(st_r.status_r & st_r.enable_r);

    a_irq_level_en: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (|(i_event & st_nxt.enable_r)) |=> o_irq)
        else $error("enabled event did not raise interrupt");
endmodule

// [verilog/udes_pkg.sv]
// udes_pkg.sv: state types of the device event and status block.
// assumes: the defines header is compiled alongside.
package udes_pkg;

    // ------------------------------------------------------------------
    // link state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UDES_LINK_ACTIVE = 2'b01,
        UDES_LINK_SUSP   = 2'b10
    } udes_link_t;

    // ------------------------------------------------------------------
    // module states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] flags_r;
    } udes_flag_state_t;

    typedef struct packed {
        logic [2:0] status_r;
        logic [2:0] enable_r;
    } udes_irq_state_t;

    typedef struct packed {
        logic [1:0]  sync1_r;
        logic [1:0]  sync2_r;
        logic [19:0] idle_cnt_r;
        udes_link_t  link_r;
        logic        awake_d_r;
        logic        ready_d_r;
        logic [31:0] rdata_r;
    } udes_main_state_t;

endpackage

// [verilog/udes_top.sv]
// udes_top.sv: device event-cause, endpoint status and bus address registers.
// assumes: endpoint, DMA and MAC inputs come from logic on i_clk; i_dp and
// i_dm are bus pins; the register port is a plain strobe port on i_clk.
//
// How it works
// - event-cause register shows which condition raised the aggregated bus event
// - CRC error on isochronous OUT endpoint 8 sets a flag; write one clears
// - bus idle long enough for suspend sets suspend flag; write one clears
// - K state or restarted activity while suspended sets resume flag
// - MAC woken and operational sets wake-up-permitted flag; write one clears
// - device becoming ready sets ready flag; write one clears
// - eight IN halted words at 0x420, stride four, usable as get-status reply
// - eight OUT halted words at 0x444, stride four, usable as get-status reply
// - DMA capture flags per IN and OUT endpoint 0-8; write one clears
// - acknowledged transfer flags endpoints 1-7 raise endpoint event; write one clears
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "udes_defines.svh"
module udes_top #(
    parameter logic [19:0] P_SUSP_IDLE_CYC = 20'(`UDES_SUSP_IDLE_CYC) // idle cycles to suspend
) (
    input  wire logic        i_clk,          // core clock, 250 MHz
    input  wire logic        i_rst_n,        // sync reset, active low
    input  wire logic [11:0] i_addr,         // register byte address
    input  wire logic [31:0] i_wdata,        // write data
    input  wire logic        i_wr,           // write strobe
    input  wire logic        i_rd,           // read strobe
    output logic      [31:0] o_rdata,        // read data, cycle after i_rd
    input  wire logic        i_dp,           // bus D+ pin
    input  wire logic        i_dm,           // bus D- pin
    input  wire logic        i_iso_crc_err,  // crc error pulse, iso OUT ep 8
    input  wire logic        i_mac_awake,    // MAC woken and operational
    input  wire logic        i_dev_ready,    // device ready for operation
    input  wire logic [8:0]  i_dma_cap_in,   // DMA capture pulses, IN 0-8
    input  wire logic [8:0]  i_dma_cap_out,  // DMA capture pulses, OUT 0-8
    input  wire logic [7:1]  i_ack_in,       // acked transfer pulses, IN 1-7
    input  wire logic [7:1]  i_ack_out,      // acked transfer pulses, OUT 1-7
    input  wire logic [7:0]  i_in_halted,    // IN endpoint halted levels
    input  wire logic [7:0]  i_out_halted,   // OUT endpoint halted levels
    input  wire logic [6:0]  i_bus_addr,     // address assigned by host
    output logic             o_bus_event,    // aggregated bus event pulse
    output logic             o_ep_xfer_event,// endpoint transfer event pulse
    output logic             o_suspended,    // link in suspend
    output logic             o_irq           // level interrupt
);
    udes_pkg::udes_main_state_t st_r;
    udes_pkg::udes_main_state_t st_nxt;

    logic [31:0] cause_set;
    logic [31:0] cause_clr;
    logic [31:0] cause_flags;
    logic [31:0] dma_set;
    logic [31:0] dma_clr;
    logic [31:0] dma_flags;
    logic [31:0] ack_set;
    logic [31:0] ack_clr;
    logic [31:0] ack_flags;
    logic [2:0]  irq_event;
    logic [2:0]  irq_clr;
    logic [2:0]  irq_status;
    logic [2:0]  irq_enable;
    logic        susp_hit;
    logic        resume_hit;
    logic        line_j;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // halted word for an address inside an eight-word block, else zero
    function automatic logic [31:0] halt_word(input logic [11:0] addr,
                                              input logic [11:0] base,
                                              input logic [7:0]  halted);
        logic [11:0] ofs;
        ofs = addr - base;
        halt_word = 32'h00000000;
        if (addr >= base && ofs < 12'(`UDES_HALT_EP_COUNT * 4) && ofs[1:0] == 2'h0) begin
            halt_word = {31'h00000000, halted[ofs[4:2]]};
        end
    endfunction

    function automatic logic [31:0] w1c(input logic [11:0] addr,
                                        input logic [11:0] target);
        w1c = (i_wr && addr == target) ? i_wdata : 32'h00000000;
    endfunction

    // ------------------------------------------------------------------
    // line state and suspend tracking
    // ------------------------------------------------------------------
    assign line_j     = (st_r.sync2_r == `UDES_LINE_J);
    assign susp_hit   = (st_r.link_r == udes_pkg::UDES_LINK_ACTIVE) && line_j
                        && (st_r.idle_cnt_r == P_SUSP_IDLE_CYC - 20'h00001);
    assign resume_hit = (st_r.link_r == udes_pkg::UDES_LINK_SUSP) && !line_j;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1_r   = {i_dp, i_dm};
        st_nxt.sync2_r   = st_r.sync1_r;
        st_nxt.awake_d_r = i_mac_awake;
        st_nxt.ready_d_r = i_dev_ready;
        case (st_r.link_r)
            udes_pkg::UDES_LINK_ACTIVE: begin
                if (!line_j) begin
                    st_nxt.idle_cnt_r = 20'h00000;
                end else if (susp_hit) begin
                    st_nxt.idle_cnt_r = 20'h00000;
                    st_nxt.link_r     = udes_pkg::UDES_LINK_SUSP;
                end else begin
                    st_nxt.idle_cnt_r = st_r.idle_cnt_r + 20'h00001;
                end
            end
            udes_pkg::UDES_LINK_SUSP: begin
                st_nxt.idle_cnt_r = 20'h00000;
                if (resume_hit) begin
                    st_nxt.link_r = udes_pkg::UDES_LINK_ACTIVE;
                end
            end
            default: begin
                st_nxt.idle_cnt_r = 20'h00000;
                st_nxt.link_r     = udes_pkg::UDES_LINK_ACTIVE;
            end
        endcase
        st_nxt.rdata_r = 32'h00000000;
        if (i_rd) begin
            case (i_addr)
                `UDES_OFS_EVT_CAUSE:  st_nxt.rdata_r = cause_flags;
                `UDES_OFS_DMA_CAP:    st_nxt.rdata_r = dma_flags;
                `UDES_OFS_ACK_XFER:   st_nxt.rdata_r = ack_flags;
                `UDES_OFS_BUS_ADDR:   st_nxt.rdata_r = {25'h0000000, i_bus_addr};
                `UDES_OFS_IRQ_STATUS: st_nxt.rdata_r = {29'h00000000, irq_status};
                `UDES_OFS_IRQ_ENABLE: st_nxt.rdata_r = {29'h00000000, irq_enable};
                default: begin
                    st_nxt.rdata_r = halt_word(i_addr, `UDES_OFS_IN_HALT, i_in_halted)
                                   | halt_word(i_addr, `UDES_OFS_OUT_HALT, i_out_halted);
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r.sync1_r    <= `UDES_LINE_J;
            st_r.sync2_r    <= `UDES_LINE_J;
            st_r.idle_cnt_r <= 20'h00000;
            st_r.link_r     <= udes_pkg::UDES_LINK_ACTIVE;
            st_r.awake_d_r  <= 1'b0;
            st_r.ready_d_r  <= 1'b0;
            st_r.rdata_r    <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // event-cause flags
    // ------------------------------------------------------------------
    // cause set pulses
    always_comb begin
        cause_set = 32'h00000000;
        cause_set[`UDES_EVT_ISO_CRC] = i_iso_crc_err;
        cause_set[`UDES_EVT_SUSPEND] = susp_hit;
        cause_set[`UDES_EVT_RESUME]  = resume_hit;
        cause_set[`UDES_EVT_WAKEUP]  = i_mac_awake && !st_r.awake_d_r;
        cause_set[`UDES_EVT_READY]   = i_dev_ready && !st_r.ready_d_r;
    end
    assign cause_clr = w1c(i_addr, `UDES_OFS_EVT_CAUSE);

    udes_flags u_cause (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_mask  (`UDES_EVT_MASK),
        .i_set   (cause_set),
        .i_clr   (cause_clr),
        .o_flags (cause_flags)
    );

    // ------------------------------------------------------------------
    // endpoint flags
    // ------------------------------------------------------------------
    // dma capture flags
    assign dma_set = {7'h00, i_dma_cap_out, 7'h00, i_dma_cap_in};
    assign dma_clr = w1c(i_addr, `UDES_OFS_DMA_CAP);
    assign ack_set = {8'h00, i_ack_out, 1'b0, 8'h00, i_ack_in, 1'b0};
    assign ack_clr = w1c(i_addr, `UDES_OFS_ACK_XFER);

    udes_flags u_dma (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_mask  (`UDES_DMA_MASK),
        .i_set   (dma_set),
        .i_clr   (dma_clr),
        .o_flags (dma_flags)
    );

    udes_flags u_ack (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_mask  (`UDES_ACK_MASK),
        .i_set   (ack_set),
        .i_clr   (ack_clr),
        .o_flags (ack_flags)
    );

    // ------------------------------------------------------------------
    // interrupts and outputs
    // ------------------------------------------------------------------
    assign o_bus_event     = |cause_set;
    assign o_ep_xfer_event = |ack_set;

    always_comb begin
        irq_event = 3'h0;
        irq_event[`UDES_IRQ_BUS_EVENT] = o_bus_event;
        irq_event[`UDES_IRQ_EP_XFER]   = o_ep_xfer_event;
        irq_event[`UDES_IRQ_DMA_CAP]   = |dma_set;
    end
    assign irq_clr = (i_wr && i_addr == `UDES_OFS_IRQ_CLEAR) ? i_wdata[2:0] : 3'h0;

    udes_irq u_irq (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_event   (irq_event),
        .i_clr     (irq_clr),
        .i_en_we   (i_wr && i_addr == `UDES_OFS_IRQ_ENABLE),
        .i_en_data (i_wdata[2:0]),
        .o_status  (irq_status),
        .o_enable  (irq_enable),
        .o_irq     (o_irq)
    );

    assign o_rdata     = st_r.rdata_r;
    assign o_suspended = (st_r.link_r == udes_pkg::UDES_LINK_SUSP);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_iso_crc_read: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_iso_crc_err
        |=> cause_flags[`UDES_EVT_ISO_CRC])
        else $error("iso crc flag not set");
    a_susp_after_idle: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        susp_hit |=> o_suspended && cause_flags[`UDES_EVT_SUSPEND])
        else $error("suspend not entered after idle count");
    a_resume_sets: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_suspended && st_r.sync2_r != `UDES_LINE_J)
        |=> !o_suspended && cause_flags[`UDES_EVT_RESUME])
        else $error("resume not flagged on activity");
    a_wakeup_rise: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_mac_awake) |=> cause_flags[`UDES_EVT_WAKEUP])
        else $error("wake-up flag not set");
    a_ready_event: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_dev_ready) |-> o_bus_event ##1 cause_flags[`UDES_EVT_READY])
        else $error("ready cause not raised");
    a_halt_in_word: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == `UDES_OFS_IN_HALT + `UDES_OFS_EP_STRIDE * 12'h003)
        |=> o_rdata == {31'h00000000, $past(i_in_halted[3])})
        else $error("IN halted word wrong");
    a_halt_out_word: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == `UDES_OFS_OUT_HALT + `UDES_OFS_EP_STRIDE * 12'h007)
        |=> o_rdata == {31'h00000000, $past(i_out_halted[7])})
        else $error("OUT halted word wrong");
    a_ack_event: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ack_out[7] |-> o_ep_xfer_event ##1 ack_flags[23])
        else $error("ack transfer not recorded");
    a_reset_clear: assert property (
        @(posedge i_clk)
        !i_rst_n |=> (cause_flags == 32'h00000000 && dma_flags == 32'h00000000
                      && ack_flags == 32'h00000000))
        else $error("flags not zero after reset");
    a_addr_read: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == `UDES_OFS_BUS_ADDR) |=> o_rdata[6:0] == $past(i_bus_addr))
        else $error("bus address readback wrong");
endmodule
